// >>> hdl/ewp_pkg.sv
// Package of the write-latch and protection block: command codes, status layout,
// protection decode and timing counts.
// Assumes a 10 MHz core clock sampling the serial link pins.
package ewp_pkg;

	// ************************************************************
	// Commands
	// ************************************************************
	localparam logic [7:0] CMD_LATCH_SET = 8'h06;
	localparam logic [7:0] CMD_LATCH_CLEAR = 8'h04;
	localparam logic [7:0] CMD_STATUS_READ = 8'h05;
	localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
	localparam logic [4:0] CMD_WRITE_MASK = 5'h1F;
	localparam logic [2:0] CMD_WRITE_LOW = 3'h2;
	localparam logic [2:0] CMD_READ_LOW = 3'h3;
	localparam logic [3:0] CMD_HIGH_NIBBLE = 4'h0;

	// ************************************************************
	// Status byte layout
	// ************************************************************
	localparam int STS_BUSY_BIT = 0;
	localparam int STS_LATCH_BIT = 1;
	localparam int STS_BP_LO_BIT = 2;
	localparam int STS_BP_HI_BIT = 3;
	localparam logic [1:0] BP_RESET = 2'h0;
	localparam logic [3:0] STS_UPPER_READ = 4'h0;

	// ************************************************************
	// Protection boundaries (9-bit array address)
	// ************************************************************
	localparam logic [8:0] PROT_QUARTER_BASE = 9'h180;
	localparam logic [8:0] PROT_HALF_BASE = 9'h100;

	// ************************************************************
	// Frame bit counts
	// ************************************************************
	localparam logic [7:0] BITS_CMD = 8'h08;
	localparam logic [7:0] BITS_STATUS_WRITE = 8'h10;
	localparam logic [7:0] BITS_ADDR_END = 8'h10;
	localparam logic [7:0] BITS_PAGE_MAX = 8'h90;

	// ************************************************************
	// Internal write time
	// ************************************************************
	localparam int CLK_PERIOD_NS = 100;
	localparam int WRITE_TIME_US = 5;
	localparam int WRITE_CYCLES = (WRITE_TIME_US * 1000) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		EWP_IDLE = 2'b00,
		EWP_CMD = 2'b01,
		EWP_DATA = 2'b10,
		EWP_SKIP = 2'b11
	} ewp_phase_e;

	typedef struct packed {
		logic frame;
		logic rise;
		logic fall;
		logic mosi;
		logic wp_n;
	} ewp_link_s;

endpackage : ewp_pkg

// >>> hdl/ewp_sync.sv
// Two-flop synchroniser bank for the serial link pins.
// Assumes pins change asynchronously to clock.
`timescale 1ns/1ps
`default_nettype none
module ewp_sync #(
	parameter int WIDTH = 4
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Data
	input wire logic [WIDTH-1:0] async_in,
	input wire logic [WIDTH-1:0] reset_val,
	output logic [WIDTH-1:0] sync_out
);

	// Flops reset to ones, the idle level of the select pin; reset_val is left unused,
	// as a reset branch may load constants only.
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			logic m_q;
			logic s_q;
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					m_q <= 1'b1;
					s_q <= 1'b1;
				end else begin
					m_q <= async_in[g];
					s_q <= m_q;
				end
			end
			assign sync_out[g] = s_q;
		end
	endgenerate

	logic unused_ok;
	assign unused_ok = ^reset_val;

endmodule : ewp_sync
`default_nettype wire

// >>> hdl/ewp_core.sv
// Write-enable latch, status register and block protection of a 512-byte
// serial memory, seen from the pins: chip select, serial clock, data in/out
// and the write-protect pin. Assumes pins are asynchronous to clock.
`timescale 1ns/1ps
`default_nettype none
module ewp_core (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Serial link pins
	input wire logic cs_n,
	input wire logic sck,
	input wire logic mosi,
	output logic miso_o,
	output logic miso_oe,
	// Write-protect pin, active low
	input wire logic wp_n,
	// Protect bits, cleared by reset, array write strobe and address towards the cell array, and status flags
	output logic [1:0] block_protect,
	output logic array_write_go,
	output logic [8:0] array_write_addr,
	output logic write_in_progress_flag,
	output logic write_latch_flag
);

	// ************************************************************
	// Pin synchronisation
	// ************************************************************
	logic [3:0] pins_s;
	ewp_sync #(.WIDTH(4)) u_sync (
		.clock(clock),
		.rst_n(rst_n),
		.async_in({cs_n, sck, mosi, wp_n}),
		.reset_val(4'hF),
		.sync_out(pins_s)
	);

	logic sck_prev_q;
	logic cs_prev_q;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sck_prev_q <= 1'b1;
			cs_prev_q <= 1'b1;
		end else begin
			sck_prev_q <= pins_s[2];
			cs_prev_q <= pins_s[3];
		end
	end

	ewp_pkg::ewp_link_s lnk;
	assign lnk.frame = !pins_s[3];
	assign lnk.rise = lnk.frame && pins_s[2] && !sck_prev_q;
	assign lnk.fall = lnk.frame && !pins_s[2] && sck_prev_q;
	assign lnk.mosi = pins_s[1];
	assign lnk.wp_n = pins_s[0];

	logic frame_end;
	logic frame_start;
	assign frame_end = pins_s[3] && !cs_prev_q;
	assign frame_start = !pins_s[3] && cs_prev_q;

	// ************************************************************
	// Shift register and bit counter
	// ************************************************************
	logic [7:0] shift_q;
	logic [7:0] bits_q;
	logic [7:0] cmd_q;
	logic [7:0] status_data_q;
	logic [8:0] addr_q;
	ewp_pkg::ewp_phase_e phase_q;
	logic busy_q;
	logic latch_q;
	logic [1:0] bp_q;

	logic [7:0] shift_next;
	assign shift_next = {shift_q[6:0], lnk.mosi};

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			shift_q <= 8'h00;
			bits_q <= 8'h00;
		end else if (frame_start) begin
			bits_q <= 8'h00;
		end else if (lnk.rise) begin
			shift_q <= shift_next;
			if (bits_q != 8'hFF) begin
				bits_q <= bits_q + 8'h01;
			end
		end
	end

	// Command byte is captured at the eighth rising edge.
	logic cmd_done;
	assign cmd_done = lnk.rise && (bits_q == ewp_pkg::BITS_CMD - 8'h01);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cmd_q <= 8'h00;
			phase_q <= ewp_pkg::EWP_IDLE;
		end else if (frame_start) begin
			phase_q <= ewp_pkg::EWP_CMD;
			cmd_q <= 8'h00;
		end else if (frame_end) begin
			phase_q <= ewp_pkg::EWP_IDLE;
		end else begin
			case (phase_q)
				ewp_pkg::EWP_CMD: begin
					if (cmd_done) begin
						cmd_q <= shift_next;
						phase_q <= ewp_pkg::EWP_DATA;
					end
				end
				ewp_pkg::EWP_DATA: begin
					if (lnk.rise && bits_q == 8'hFE) begin
						phase_q <= ewp_pkg::EWP_SKIP;
					end
				end
				ewp_pkg::EWP_SKIP: begin
				end
				ewp_pkg::EWP_IDLE: begin
				end
				default: begin
					phase_q <= ewp_pkg::EWP_IDLE;
				end
			endcase
		end
	end

	// ************************************************************
	// Command decode
	// ************************************************************
	logic is_array_write;
	logic is_status_read;
	assign is_array_write = (cmd_q[7:4] == ewp_pkg::CMD_HIGH_NIBBLE)
		&& (cmd_q[2:0] == ewp_pkg::CMD_WRITE_LOW);
	assign is_status_read = (cmd_q == ewp_pkg::CMD_STATUS_READ);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			addr_q <= 9'h000;
			status_data_q <= 8'h00;
		end else if (lnk.rise && phase_q == ewp_pkg::EWP_DATA) begin
			if (bits_q == ewp_pkg::BITS_ADDR_END - 8'h01) begin
				addr_q <= {cmd_q[3], shift_next};
			end
			if (bits_q == ewp_pkg::BITS_STATUS_WRITE - 8'h01) begin
				status_data_q <= shift_next;
			end
		end
	end

	// Whole data bytes after address, up to one page.
	logic write_count_ok;
	assign write_count_ok = (bits_q > ewp_pkg::BITS_ADDR_END)
		&& (bits_q <= ewp_pkg::BITS_PAGE_MAX)
		&& (bits_q[2:0] == 3'h0);

	logic addr_protected;
	always_comb begin
		case (bp_q)
			2'b00: addr_protected = 1'b0;
			2'b01: addr_protected = (addr_q >= ewp_pkg::PROT_QUARTER_BASE);
			2'b10: addr_protected = (addr_q >= ewp_pkg::PROT_HALF_BASE);
			2'b11: addr_protected = 1'b1;
			default: addr_protected = 1'b1;
		endcase
	end

	logic end_ok;
	assign end_ok = frame_end && !busy_q && lnk.wp_n;
	logic go_set;
	logic go_clear;
	logic go_status;
	logic go_array;
	assign go_set = frame_end && (bits_q == ewp_pkg::BITS_CMD)
		&& (cmd_q == ewp_pkg::CMD_LATCH_SET);
	assign go_clear = frame_end && (bits_q == ewp_pkg::BITS_CMD)
		&& (cmd_q == ewp_pkg::CMD_LATCH_CLEAR);
	assign go_status = end_ok && latch_q && (bits_q == ewp_pkg::BITS_STATUS_WRITE)
		&& (cmd_q == ewp_pkg::CMD_STATUS_WRITE);
	assign go_array = end_ok && latch_q && is_array_write && write_count_ok
		&& !addr_protected;

	// ************************************************************
	// Internal write cycle timer
	// ************************************************************
	logic [15:0] timer_q;
	logic timer_done;
	assign timer_done = busy_q && (timer_q == 16'h0000);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			busy_q <= 1'b0;
			timer_q <= 16'h0000;
		end else if (go_status || go_array) begin
			busy_q <= 1'b1;
			timer_q <= 16'(ewp_pkg::WRITE_CYCLES - 1);
		end else if (timer_done) begin
			busy_q <= 1'b0;
		end else if (busy_q) begin
			timer_q <= timer_q - 16'h0001;
		end
	end

	logic status_pending_q;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			status_pending_q <= 1'b0;
			bp_q <= ewp_pkg::BP_RESET;
		end else if (go_status) begin
			status_pending_q <= 1'b1;
		end else if (timer_done && status_pending_q) begin
			status_pending_q <= 1'b0;
			bp_q <= {status_data_q[ewp_pkg::STS_BP_HI_BIT],
				status_data_q[ewp_pkg::STS_BP_LO_BIT]};
		end
	end

	// ************************************************************
	// Write-enable latch
	// ************************************************************
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			latch_q <= 1'b0;
		end else if (!lnk.wp_n) begin
			latch_q <= 1'b0;
		end else if (go_set) begin
			// A set landing on the last write cycle wins over the end-of-write clear.
			latch_q <= 1'b1;
		end else if (timer_done || go_clear) begin
			latch_q <= 1'b0;
		end
	end

	// ************************************************************
	// Status read-out, shifted after each falling edge
	// ************************************************************
	logic [7:0] status_byte;
	assign status_byte = {ewp_pkg::STS_UPPER_READ, bp_q, latch_q, busy_q};

	logic [7:0] out_shift_q;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			out_shift_q <= 8'h00;
			miso_o <= 1'b0;
			miso_oe <= 1'b0;
		end else if (!lnk.frame) begin
			miso_oe <= 1'b0;
			miso_o <= 1'b0;
		end else if (lnk.fall && phase_q == ewp_pkg::EWP_DATA && is_status_read) begin
			miso_oe <= 1'b1;
			if (bits_q[2:0] == 3'h0) begin
				miso_o <= status_byte[7];
				out_shift_q <= {status_byte[6:0], 1'b0};
			end else begin
				miso_o <= out_shift_q[7];
				out_shift_q <= {out_shift_q[6:0], 1'b0};
			end
		end
	end

	// ************************************************************
	// Registered outputs
	// ************************************************************
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			block_protect <= ewp_pkg::BP_RESET;
			array_write_go <= 1'b0;
			array_write_addr <= 9'h000;
			write_in_progress_flag <= 1'b0;
			write_latch_flag <= 1'b0;
		end else begin
			block_protect <= bp_q;
			array_write_go <= go_array;
			array_write_addr <= addr_q;
			write_in_progress_flag <= busy_q;
			write_latch_flag <= latch_q;
		end
	end

endmodule : ewp_core
`default_nettype wire

// >>> verification/ewp_properties.sv
// Checker of the write latch, busy and protection outputs.
// Assumes a bind to ewp_core; it sees that module's ports only.
`timescale 1ns/1ps
`default_nettype none
module ewp_properties (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Link pins
	input wire logic cs_n,
	input wire logic sck,
	input wire logic mosi,
	input wire logic miso_o,
	input wire logic miso_oe,
	input wire logic wp_n,
	// Status and array side
	input wire logic [1:0] block_protect,
	input wire logic array_write_go,
	input wire logic [8:0] array_write_addr,
	input wire logic write_in_progress_flag,
	input wire logic write_latch_flag
);
	// ********
	// Helpers
	// ********
	wire busy = write_in_progress_flag;
	wire latch = write_latch_flag;
	wire [1:0] bp = block_protect;
	wire [8:0] ad = array_write_addr;
	logic [7:0] busy_cnt_q;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			busy_cnt_q <= 8'h00;
		end else if (busy) begin
			busy_cnt_q <= busy_cnt_q + 8'h01;
		end else begin
			busy_cnt_q <= 8'h00;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	// ********
	// Properties
	// ********
	a_busy_len: assert property ($fell(busy) |-> busy_cnt_q == ewp_pkg::WRITE_CYCLES)
		else $error("Busy time wrong.");
	a_latch_end: assert property ($fell(busy) |-> !latch
		|| ($past(cs_n, 4) && !$past(cs_n, 5)))
		else $error("Latch kept after write.");
	a_start_latch: assert property ($rose(busy) |-> $past(latch) && cs_n)
		else $error("Write began without latch.");
	a_go_latch: assert property (array_write_go |-> latch ##1 busy)
		else $error("Array write without latch.");
	a_go_idle: assert property (array_write_go |-> !busy)
		else $error("Array write during busy.");
	a_go_prot: assert property (array_write_go |-> bp != 2'h3
		&& !(bp == 2'h1 && ad >= 9'h180) && !(bp == 2'h2 && ad >= 9'h100))
		else $error("Protected block written.");
	a_bp_only: assert property ($changed(bp) |-> !busy
		&& ($past(busy) || $past(busy, 2)))
		else $error("Protect bits moved outside write.");
	a_wp_clear: assert property (!wp_n [*5] |-> !latch)
		else $error("Latch set with protect pin low.");
	a_set_frame: assert property ($rose(latch) |-> cs_n && wp_n)
		else $error("Latch rose inside frame.");
	a_out_idle: assert property (cs_n [*5] |-> !miso_oe)
		else $error("Output driven while deselected.");
	c_write: cover property ($fell(busy));
	c_go: cover property (array_write_go);
	c_read: cover property (miso_oe);
endmodule : ewp_properties
bind ewp_core ewp_properties u_props (.clock(clock), .rst_n(rst_n), .cs_n(cs_n), .sck(sck),
	.mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe), .wp_n(wp_n),
	.block_protect(block_protect), .array_write_go(array_write_go),
	.array_write_addr(array_write_addr), .write_in_progress_flag(write_in_progress_flag),
	.write_latch_flag(write_latch_flag));
`default_nettype wire

// >>> verification/ewp_host.sv
// Host side of the serial link: frames commands and shifts status back.
// Assumes the 100 ns core clock; one link bit takes eight of its cycles.
`timescale 1ns/1ps
`default_nettype none
module ewp_host (
	// Clock
	input wire logic clock,
	// Link
	input wire logic miso_o,
	output logic cs_n,
	output logic sck,
	output logic mosi
);
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		mosi = 1'b0;
	end
	// Sends the low n bits of d; the sck clock stands low between frames.
	task automatic xfer(input logic [23:0] d, input int n, output logic [7:0] r);
		r = 8'h00;
		cs_n <= 1'b0;
		repeat (4) @(posedge clock);
		for (int i = n - 1; i >= 0; i--) begin
			mosi <= d[i];
			repeat (4) @(posedge clock);
			sck <= 1'b1;
			repeat (4) @(posedge clock);
			r = {r[6:0], miso_o};
			sck <= 1'b0;
		end
		repeat (4) @(posedge clock);
		cs_n <= 1'b1;
		mosi <= ~mosi;
		repeat (8) @(posedge clock);
	endtask : xfer
endmodule : ewp_host
`default_nettype wire

// >>> verification/tb_ewp_core.sv
// Testbench of ewp_core: command frames through the host model.
// Assumes ewp_host and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
	$display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb_ewp_core;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic wp_n = 1'b1;
	logic cs_n, sck, mosi, miso_o, miso_oe, awg, busy_flag, latch_flag, ok, go_seen;
	logic [1:0] bp, b;
	logic [8:0] waddr, a, go_addr;
	logic [7:0] r;
	logic [8:0] addrs [4] = '{9'h0FF, 9'h100, 9'h17F, 9'h180};
	int num_errors = 0;
	int check_count = 0;
	initial begin
		forever #50 clock = ~clock;
	end
	ewp_core DUT (.clock(clock), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .mosi(mosi),
		.miso_o(miso_o), .miso_oe(miso_oe), .wp_n(wp_n), .block_protect(bp),
		.array_write_go(awg), .array_write_addr(waddr), .write_in_progress_flag(busy_flag),
		.write_latch_flag(latch_flag));
	ewp_host u_host (.clock(clock), .miso_o(miso_o), .cs_n(cs_n), .sck(sck), .mosi(mosi));
	always @(posedge clock) begin
		if (awg === 1'b1) begin
			go_seen <= 1'b1;
			go_addr <= waddr;
		end
	end
	task end_sim;
		if (num_errors == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_sim
	task tx(input logic [23:0] d, input int n);
		u_host.xfer(d, n, r);
	endtask : tx
	task rd(input logic [7:0] e);
		u_host.xfer(24'h000500, 16, r);
		`CHK("status", e, r)
	endtask : rd
	initial begin
		repeat (20000) @(posedge clock);
		num_errors++;
		end_sim;
	end
	initial begin
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		repeat (4) @(posedge clock);
		`CHK("idle", 6'h00, {miso_oe, bp, awg, busy_flag, latch_flag})
		rd(8'h00);
		tx(24'h000006, 7);
		`CHK("short set", 1'b0, latch_flag)
		tx(24'h000006, 8);
		`CHK("set", 1'b1, latch_flag)
		rd(8'h02);
		tx(24'h000004, 8);
		`CHK("clear", 1'b0, latch_flag)
		tx(24'h00010C, 16);
		repeat (60) @(posedge clock);
		`CHK("no latch", 2'h0, bp)
		tx(24'h000006, 8);
		tx(24'h000218, 17);
		repeat (60) @(posedge clock);
		`CHK("long frame", 2'h0, bp)
		for (int k = 0; k < 4; k++) begin
			b = 2'(k + 1);
			tx(24'h000006, 8);
			tx({8'h00, 8'h01, 4'h0, b, 2'h0}, 16);
			`CHK("busy", 1'b1, busy_flag)
			// The read frame opens while the write runs and must not be refused.
			rd({4'h0, b, 2'h0});
			`CHK("bp", b, bp)
			`CHK("latch end", 1'b0, latch_flag)
			rd({4'h0, b, 2'h0});
			for (int j = 0; j < 4; j++) begin
				a = addrs[j];
				tx(24'h000006, 8);
				go_seen <= 1'b0;
				tx({4'h0, a[8], 3'h2, a[7:0], 8'hA5}, 24);
				repeat (60) @(posedge clock);
				ok = b == 0 || (b == 1 && a < 9'h180) || (b == 2 && a < 9'h100);
				`CHK("go", ok, go_seen)
				if (ok) `CHK("addr", a, go_addr)
			end
		end
		tx(24'h000006, 8);
		tx(24'h000108, 16);
		wp_n <= 1'b0;
		repeat (60) @(posedge clock);
		`CHK("wp spares", 2'h2, bp)
		tx(24'h000006, 8);
		`CHK("wp refuses", 1'b0, latch_flag)
		wp_n <= 1'b1;
		tx(24'h000006, 8);
		`CHK("set again", 1'b1, latch_flag)
		wp_n <= 1'b0;
		repeat (8) @(posedge clock);
		`CHK("wp clears", 1'b0, latch_flag)
		end_sim;
	end
endmodule : tb_ewp_core
`default_nettype wire
